// ==== design/input_noise_filter.v ====
/*
 Noise filter: takes a level only after it has stood for a set number
 of base clock samples.
 Assumes the input is already synchronised to mclk and polarity-fixed.
*/
`timescale 1ns/1ps
`include "ir_receiver_defs.vh"
module input_noise_filter #(
    parameter [2:0] SAMPLES = `FILTER_SAMPLES
) (
    input wire mclk,        // system clock
    input wire resetn,      // synchronous reset, active low
    input wire clear,       // restart at the inactive level
    input wire sample,      // base clock enable
    input wire din,         // synchronised input, 1 = active
    output reg dout         // filtered level
);
    reg [2:0] same_cnt_r;

    // a sample unlike the held level counts up; any match restarts the
    // count, so a pulse can be shortened by up to one base clock
    always @(posedge mclk) begin
        if (!resetn || clear) begin
            dout <= 1'b0;
            same_cnt_r <= 3'h0;
        end else if (sample) begin
            if (din == dout) begin
                same_cnt_r <= 3'h0;
            end else if (same_cnt_r == SAMPLES - 3'h1) begin
                dout <= din;
                same_cnt_r <= 3'h0;
            end else begin
                same_cnt_r <= same_cnt_r + 3'h1;
            end
        end
    end
endmodule // input_noise_filter

// ==== design/ir_receiver.v ====
/*
 Infrared remote receiver: APB register file, base clock select, input
 synchroniser, pulse width timing, bit counting, shift and data
 registers, flags and the interrupt / hold release outputs.
 Assumes an APB master on mclk, a demodulated input pin and a subclock
 pin, both asynchronous, and a crystal hold level from power control.
*/
`timescale 1ns/1ps
`include "ir_receiver_defs.vh"
module ir_receiver #(
    parameter ADDR_W = 18
) (
    input wire mclk,                // 250 MHz system clock
    input wire resetn,              // synchronous reset, active low
    input wire psel,                // apb select
    input wire penable,             // apb access phase
    input wire pwrite,              // apb direction, 1 = write
    input wire [ADDR_W-1:0] paddr,  // apb byte address
    input wire [31:0] pwdata,       // apb write data
    output reg [31:0] prdata,       // apb read data
    output reg pready,              // apb ready
    output reg pslverr,             // apb error on unmapped address
    input wire ir_in,               // demodulated infrared input pin
    input wire subclock,            // subclock oscillation pin
    input wire xtal_hold,           // crystal hold mode, cycle clock off
    output reg irq,                 // receiver interrupt request
    output reg hold_release         // crystal hold release request
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_GUIDE_H = 3'h1;
    localparam [2:0] ST_GUIDE_L = 3'h2;
    localparam [2:0] ST_DATA_H = 3'h3;
    localparam [2:0] ST_DATA_L = 3'h4;
    localparam [2:0] ST_SUSP = 3'h5;

    reg [7:0] ctrl_r;
    reg [7:0] irq_ctl_r;
    reg [7:0] shift_r;
    reg [7:0] data_r;
    reg [3:0] ctpr_sel_r;
    reg suspend_r;
    reg [2:0] bit_cnt_r;
    reg [7:0] gpw_r;
    reg [7:0] dt0w_r;
    reg [7:0] dt1w_r;
    reg [6:0] xhw_r;
    reg [2:0] state_r;
    reg [4:0] pw_cnt_r;
    reg [6:0] div_cnt_r;
    reg [2:0] sub_sync_r;
    reg [1:0] in_sync_r;
    reg sig_prev_r;
    reg run_prev_r;

    wire run = ctrl_r[`CTRL_RUN];
    wire [2:0] fmt = ctrl_r[`CTRL_FMT_HI:`CTRL_FMT_LO];
    wire [2:0] ck_sel = ctrl_r[`CTRL_CK_HI:`CTRL_CK_LO];
    wire rdir = xhw_r[6];   // direction kept just above the six width msbs

    // format decode: 0,1,4 use a guide, 3,4 are manchester
    wire fmt_guide = (fmt == 3'h0) || (fmt == 3'h1) || (fmt == 3'h4);
    wire fmt_short = (fmt == 3'h3) || (fmt == 3'h4);

    // widths: msb from the high register, four low bits from a nibble of the rest (guide high uses gpw_r[7:4])
    wire [4:0] gph_w = {xhw_r[`XHW_GPH], gpw_r[7:4]};
    wire [4:0] gpl_w = {xhw_r[`XHW_GPL], gpw_r[3:0]};
    wire [4:0] d0l_w = {xhw_r[`XHW_D0L], dt0w_r[3:0]};
    wire [4:0] d1l_w = {xhw_r[`XHW_D1L], dt1w_r[3:0]};

    // apb decode; a transfer completes on the edge that sees pready
    wire apb_done = psel && penable && pready;
    wire wr_en = apb_done && pwrite;
    wire rd_en = apb_done && !pwrite;
    wire [15:0] idx = paddr[17:2];
    wire sel_ctrl = (idx == `IDX_CTRL);
    wire sel_irq = (idx == `IDX_IRQ);
    wire sel_shift = (idx == `IDX_SHIFT);
    wire sel_ctpr = (idx == `IDX_CTPR);

    // base clock: divider of the cycle clock or the synchronised
    // subclock edge; the cycle clock taps die in crystal hold
    wire [6:0] div_mask = (7'h04 << ck_sel) - 7'h01;
    wire sub_edge = sub_sync_r[1] && !sub_sync_r[2];
    reg base_tick;
    always @* begin
        if (ck_sel == `CK_SUBCLOCK) begin
            base_tick = run && sub_edge;
        end else if (xtal_hold) begin
            base_tick = 1'b0;
        end else if (ck_sel == `CK_ONE_TCYC) begin
            base_tick = run;
        end else begin
            base_tick = run && ((div_cnt_r & div_mask) == div_mask);
        end
    end

    // restart of filter and counters whenever running is off
    wire halted = !run;
    wire start_now = run && !run_prev_r;

    // input pin through two flops, then polarity, then the filter
    wire in_polar = in_sync_r[1] ^ ctrl_r[`CTRL_INV];
    wire sig;
    input_noise_filter u_filter (
        .mclk(mclk),
        .resetn(resetn),
        .clear(halted),
        .sample(base_tick),
        .din(in_polar),
        .dout(sig)
    );

    // the filter restarts at the inactive level, so an input already
    // active at start shows up as a rising edge after filtering
    wire rise = sig && !sig_prev_r;
    wire fall = !sig && sig_prev_r;
    wire edge_seen = rise || fall;

    // guide states use the guide select, all others the data select
    wire in_guide = (state_r == ST_GUIDE_H) || (state_r == ST_GUIDE_L);
    wire [1:0] psc_sel = in_guide ? ctpr_sel_r[3:2] : ctpr_sel_r[1:0];
    wire pw_tick;
    receive_prescaler u_prescaler (
        .mclk(mclk),
        .resetn(resetn),
        .clear(halted || edge_seen),
        .tick(base_tick),
        .sel(psc_sel),
        .short_div(fmt_short),
        .count_pulse(pw_tick)
    );

    wire pw_full = (pw_cnt_r == 5'h1F);

    // decoder outcomes for this cycle
    reg [2:0] state_nxt;
    reg guide_ok;
    reg bit_ok;
    reg bit_val;
    reg bit_err;
    reg rx_end;
    reg first_rise;
    always @* begin
        state_nxt = state_r;
        guide_ok = 1'b0;
        bit_ok = 1'b0;
        bit_val = 1'b0;
        bit_err = 1'b0;
        rx_end = 1'b0;
        first_rise = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (rise && fmt_guide) begin
                    state_nxt = ST_GUIDE_H;
                end else if (rise) begin
                    first_rise = 1'b1;
                    state_nxt = ST_DATA_H;
                end
            end
            ST_GUIDE_H: begin
                // never entered in formats 2 and 3, so the guide
                // select and width cannot touch them
                if (fall && pw_cnt_r >= gph_w) begin
                    if (fmt == 3'h0) begin
                        guide_ok = 1'b1;
                        state_nxt = ST_DATA_L;
                    end else begin
                        state_nxt = ST_GUIDE_L;
                    end
                end else if (fall) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_GUIDE_L: begin
                if (rise && pw_cnt_r >= gpl_w) begin
                    guide_ok = 1'b1;
                    state_nxt = ST_DATA_H;
                end else if (rise || pw_full) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DATA_H: begin
                if (pw_full) begin
                    rx_end = 1'b1;
                    state_nxt = ST_SUSP;
                end else if (fall) begin
                    state_nxt = ST_DATA_L;
                end
            end
            ST_DATA_L: begin
                if (pw_full) begin
                    rx_end = 1'b1;
                    state_nxt = ST_SUSP;
                end else if (rise) begin
                    state_nxt = ST_DATA_H;
                    if (pw_cnt_r >= d1l_w) begin
                        bit_ok = 1'b1;
                        bit_val = 1'b1;
                    end else if (pw_cnt_r >= d0l_w) begin
                        bit_ok = 1'b1;
                    end else begin
                        bit_err = 1'b1;
                    end
                end
            end
            ST_SUSP: begin
                if (!suspend_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // shift register with direction, eight bits move to data register
    wire [7:0] shift_in = rdir ? {shift_r[6:0], bit_val}
                               : {bit_val, shift_r[7:1]};
    wire byte_done = bit_ok && (bit_cnt_r == 3'h7);

    // synchronisers, edge history and the cycle clock divider
    always @(posedge mclk) begin
        if (!resetn) begin
            in_sync_r <= 2'h0;
            sub_sync_r <= 3'h0;
            sig_prev_r <= 1'b0;
            run_prev_r <= 1'b0;
            div_cnt_r <= 7'h00;
        end else begin
            in_sync_r <= {in_sync_r[0], ir_in};
            sub_sync_r <= {sub_sync_r[1:0], subclock};
            sig_prev_r <= sig;
            run_prev_r <= run;
            div_cnt_r <= start_now ? 7'h00 : div_cnt_r + 7'h01;
        end
    end

    // decoder state, width counter, bit counter and data path
    always @(posedge mclk) begin
        if (!resetn || halted) begin
            state_r <= ST_IDLE;
            pw_cnt_r <= 5'h00;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (edge_seen) begin
                pw_cnt_r <= 5'h00;
            end else if (pw_tick && !pw_full) begin
                pw_cnt_r <= pw_cnt_r + 5'h01;
            end
            if (guide_ok || first_rise) begin
                bit_cnt_r <= 3'h0;
                shift_r <= 8'h00;
            end else if (byte_done) begin
                bit_cnt_r <= 3'h0;
                shift_r <= 8'h00;
            end else if (bit_ok) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                shift_r <= shift_in;
            end
        end
    end

    // data register holds the last full byte; no reset value needed
    always @(posedge mclk) begin
        if (byte_done) begin
            data_r <= shift_in;
        end
    end

    // configuration registers; software changes them only while
    // stopped, the block does not guard against live changes
    always @(posedge mclk) begin
        if (!resetn) begin
            ctrl_r <= `RST_BYTE;
            ctpr_sel_r <= 4'h0;
            gpw_r <= `RST_BYTE;
            dt0w_r <= `RST_BYTE;
            dt1w_r <= `RST_BYTE;
            xhw_r <= 7'h00;
        end else if (wr_en) begin
            if (sel_ctrl) begin
                ctrl_r <= pwdata[7:0];
            end else if (sel_ctpr) begin
                ctpr_sel_r <= pwdata[7:4];
            end else if (idx == `IDX_GPW) begin
                gpw_r <= pwdata[7:0];
            end else if (idx == `IDX_DT0W) begin
                dt0w_r <= pwdata[7:0];
            end else if (idx == `IDX_DT1W) begin
                dt1w_r <= pwdata[7:0];
            end else if (idx == `IDX_XHW) begin
                xhw_r <= {pwdata[`XHW_RDIR], pwdata[5:0]};
            end
        end
    end

    // sticky flags: hardware set beats a software write of zero,
    // enables are plain read/write
    wire clr_irq = wr_en && sel_irq;
    wire [7:0] irq_set = {guide_ok, 1'b0, bit_err, 1'b0,
                          byte_done, 1'b0, rx_end, 1'b0};
    wire [7:0] flag_mask = 8'hAA;
    always @(posedge mclk) begin
        if (!resetn) begin
            irq_ctl_r <= `RST_BYTE;
        end else begin
            irq_ctl_r <= irq_set | (clr_irq ?
                ((pwdata[7:0] & irq_ctl_r & flag_mask)
                 | (pwdata[7:0] & ~flag_mask)) :
                irq_ctl_r);
        end
    end

    // suspend: set at the end of a reception, cleared by reading the
    // shift register or by stopping; the end event wins a tie
    always @(posedge mclk) begin
        if (!resetn || halted) begin
            suspend_r <= 1'b0;
        end else if (rx_end) begin
            suspend_r <= 1'b1;
        end else if (rd_en && sel_shift) begin
            suspend_r <= 1'b0;
        end
    end

    // interrupt and hold release share one request
    wire req_any = |(irq_ctl_r[7:0] & flag_mask
                     & {irq_ctl_r[6:0], 1'b0});
    always @(posedge mclk) begin
        if (!resetn) begin
            irq <= 1'b0;
            hold_release <= 1'b0;
        end else begin
            irq <= req_any;
            hold_release <= req_any;
        end
    end

    // apb slave: one wait state, read data and error registered
    reg [7:0] rd_byte;
    reg rd_hit;
    always @* begin
        rd_hit = 1'b1;
        if (sel_ctrl) begin
            rd_byte = ctrl_r;
        end else if (sel_irq) begin
            rd_byte = irq_ctl_r;
        end else if (sel_shift) begin
            rd_byte = shift_r;
        end else if (idx == `IDX_DATA) begin
            rd_byte = data_r;
        end else if (sel_ctpr) begin
            rd_byte = {ctpr_sel_r, suspend_r, bit_cnt_r};
        end else if (idx == `IDX_GPW) begin
            rd_byte = gpw_r;
        end else if (idx == `IDX_DT0W) begin
            rd_byte = dt0w_r;
        end else if (idx == `IDX_DT1W) begin
            rd_byte = dt1w_r;
        end else if (idx == `IDX_XHW) begin
            rd_byte = {xhw_r[6], 1'b0, xhw_r[5:0]};
        end else begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !rd_hit;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= {24'h000000, rd_byte};
            end
        end
    end
endmodule // ir_receiver

// ==== design/ir_receiver_defs.vh ====
/*
 Constants of the infrared remote receiver: register indices, field
 positions, reset values, base clock select codes and the filter length.
 Assumes the includer reaches a register at byte address index * 4.
*/
// How it works
// - a 3-bit counter counts every data bit classified as 0 or 1
// - bit counter clears when stopped, on good guide, or first rise (fmt 2/3)
// - formats 2 and 3 ignore guide prescale select and guide width
// - 5-bit prescaler counts base clocks and pulses the width counter
// - prescale select comes from bits 7:6 in guide, 5:4 in data
// - formats 0 to 2 divide by 4, 8, 16 or 32
// - formats 3 and 4 divide by 2, 4, 8 or 16
// - 8-bit data zero and data one width registers set pulse widths
// - 7-bit high register holds width msbs and shift direction
// - 5-bit width counter runs on prescaler pulses and times pulses
// - input accepted only after four equal base clock samples
// - run bit 7 low halts, high starts and waits for input
// - format codes pick guide kind, ppm or manchester, stop bit
// - input already active at start counts as a start edge
// - base clock codes pick 4 to 128 cycles, subclock, or 1 cycle
// - in crystal hold only the subclock base clock keeps running
// - guide flag bit 7 sets on good guide, sticky until cleared
// - guide flag with its enable raises hold release and interrupt
// - error flag bit 5 sets on a data check error, sticky
// - byte flag sets on eight bits moved to data register, sticky
// - end flag sets on end of format, sticky, also with its enable off
// - suspend flag sets at end, clears on shift read or stop
// - direction bit low loads lsb first, high loads msb first
`ifndef IR_RECEIVER_DEFS_VH
`define IR_RECEIVER_DEFS_VH

`define IDX_CTRL 16'hFEC7
`define IDX_IRQ 16'hFEC8
`define IDX_SHIFT 16'hFEC9
`define IDX_DATA 16'hFECA
`define IDX_CTPR 16'hFECB
`define IDX_GPW 16'hFECC
`define IDX_DT0W 16'hFECD
`define IDX_DT1W 16'hFECE
`define IDX_XHW 16'hFECF

`define RST_BYTE 8'h00

// control fields
`define CTRL_RUN 7
`define CTRL_FMT_HI 6
`define CTRL_FMT_LO 4
`define CTRL_INV 3
`define CTRL_CK_HI 2
`define CTRL_CK_LO 0

// interrupt control fields
`define IRQ_GPOK 7
`define IRQ_GPIE 6
`define IRQ_DERR 5
`define IRQ_ERIE 4
`define IRQ_SFUL 3
`define IRQ_SFIE 2
`define IRQ_REND 1
`define IRQ_ENIE 0

// high width register fields
`define XHW_RDIR 7
`define XHW_D1H 5
`define XHW_D1L 4
`define XHW_D0H 3
`define XHW_D0L 2
`define XHW_GPH 1
`define XHW_GPL 0

// base clock select codes
`define CK_SUBCLOCK 3'h6
`define CK_ONE_TCYC 3'h7

// noise filter length in base clocks
`define FILTER_SAMPLES 3'h4

`endif

// ==== design/receive_prescaler.v ====
/*
 Receive prescaler: 5-bit up-counter on the base clock that pulses the
 pulse width counter every 2 to 32 base clocks.
 Assumes the caller restarts it at each measured edge.
*/
`timescale 1ns/1ps
module receive_prescaler (
    input wire mclk,        // system clock
    input wire resetn,      // synchronous reset, active low
    input wire clear,       // restart the count
    input wire tick,        // base clock enable
    input wire [1:0] sel,   // count select code
    input wire short_div,   // formats 3 and 4 halve the count
    output reg count_pulse  // one-cycle pulse to the width counter
);
    reg [4:0] cnt_r;
    wire [5:0] div_len;

    // 4,8,16,32 or 2,4,8,16 base clocks per pulse
    assign div_len = short_div ? (6'h02 << sel) : (6'h04 << sel);

    always @(posedge mclk) begin
        if (!resetn || clear) begin
            cnt_r <= 5'h00;
            count_pulse <= 1'b0;
        end else begin
            count_pulse <= 1'b0;
            if (tick) begin
                if ({1'b0, cnt_r} == div_len - 6'h01) begin
                    cnt_r <= 5'h00;
                    count_pulse <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 5'h01;
                end
            end
        end
    end
endmodule // receive_prescaler

// ==== testbench/ir_receiver_checker.sv ====
/*
 Port checker for the infrared receiver: bus timing and interrupt outputs.
 Assumes the top keeps one wait state and is bound in below.
*/
`timescale 1ns/1ps
module ir_receiver_checker #(
    parameter ADDR_W = 18
) (
    input wire mclk,                // system clock
    input wire resetn,              // synchronous reset, active low
    input wire psel,                // apb select
    input wire penable,             // apb access phase
    input wire pwrite,              // apb direction
    input wire [ADDR_W-1:0] paddr,  // apb byte address
    input wire [31:0] pwdata,       // apb write data
    input wire [31:0] prdata,       // apb read data
    input wire pready,              // apb ready
    input wire pslverr,             // apb error
    input wire irq,                 // interrupt request
    input wire hold_release         // hold release request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // register index of the current transfer
    wire [15:0] idx;
    assign idx = paddr[ADDR_W-1:2];
    wire mapped;
    assign mapped = idx >= 16'hFEC7 && idx <= 16'hFECF;
    sequence access_wait;
        psel && penable && !pready;
    endsequence
    // writing zero drops every enable, so no flag may hold irq up
    sequence enables_off;
        pready && pwrite && idx == 16'hFEC8 && pwdata[7:0] == 8'h00;
    endsequence
    AST_ONE_WAIT: assert property (access_wait |=> pready)
        else $error("ready not in second access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_UNMAPPED_ERR: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 0)
        else $error("read data upper bits set");
    AST_HOLD_IS_IRQ: assert property (hold_release == irq)
        else $error("hold release differs from irq");
    AST_IRQ_OFF: assert property (enables_off |=> ##1 !irq)
        else $error("irq stays with enables off");
    AST_XHW_GAP: assert property (pready && !pwrite && idx == 16'hFECF
        |-> !prdata[6])
        else $error("unused width bit reads one");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !resetn |=> !pready && !irq && !hold_release)
        else $error("outputs active after reset");
endmodule // ir_receiver_checker

bind ir_receiver ir_receiver_checker #(.ADDR_W(ADDR_W)) chk (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .hold_release(hold_release));

// ==== testbench/ir_source.sv ====
/*
 Behavioural infrared source on the receiver input line.
 Assumes format 2 timing: a bit is told by its low time before a rise.
*/
`timescale 1ns/1ps
module ir_source (
    input wire mclk,      // system clock
    output logic ir_line  // demodulated line to the receiver
);
    logic lvl = 1'b0;
    logic inv = 1'b0;
    // the line is inverted to match the polarity software chose
    assign ir_line = lvl ^ inv;
    // one level for n+1 cycles when called back to back, changed just after an edge
    task hold(input logic v, input int n);
        @(posedge mclk);
        lvl <= v;
        repeat (n) @(posedge mclk);
    endtask
    // bad bits get a low too short for either width
    task send(input [15:0] bits, input int n, input [15:0] bad);
        for (int i = 0; i < n; i++) begin
            hold(1'b1, 16);
            hold(1'b0, bad[i] ? 6 : (bits[i] ? 32 : 16));
        end
        hold(1'b1, 16); // stop bit closes the last data bit
        hold(1'b0, 1);
    endtask
    task glitch;
        hold(1'b1, 2);
        hold(1'b0, 40);
    endtask
endmodule // ir_source

// ==== testbench/tb.sv ====
/*
 Self-checking bench for the infrared receiver: registers, two frames.
 Assumes one wait state per bus transfer and the ir_source partner.
*/
`timescale 1ns/1ps
`include "ir_receiver_defs.vh"
module tb;
    logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0;
    logic xhold = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, ir_in, irq, hold_release;
    int fails = 0, tests_run = 0;
    logic [7:0] q;
    logic e;
    // index, write value, read back, error; written while stopped
    logic [32:0] rows [0:8] = '{{16'hFEC7, 8'h2F, 8'h2F, 1'b0},
        {16'hFEC8, 8'hFF, 8'h55, 1'b0}, {16'hFEC9, 8'hFF, 8'h00, 1'b0},
        {16'hFECB, 8'hFF, 8'hF0, 1'b0}, {16'hFECC, 8'hA5, 8'hA5, 1'b0},
        {16'hFECD, 8'h5A, 8'h5A, 1'b0}, {16'hFECE, 8'h3C, 8'h3C, 1'b0},
        {16'hFECF, 8'hFF, 8'hBF, 1'b0}, {16'hFED0, 8'h11, 8'h00, 1'b1}};
    ir_receiver dut (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ir_in(ir_in),
        .subclock(1'b0), .xtal_hold(xhold), .irq(irq),
        .hold_release(hold_release));
    ir_source src (.mclk(mclk), .ir_line(ir_in));
    initial forever #2 mclk = ~mclk;
    task chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus transfer, held until ready is seen at an edge
    task apb(input w, input [15:0] idx, input [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            fails++;
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll the suspend bit; a frame ends by width counter overflow
    task wait_end(input [7:0] exp);
        int n;
        n = 0;
        do begin
            apb(1'b0, `IDX_CTPR, 8'h00);
            n++;
        end while (q[3] !== 1'b1 && n < 100);
        chk({24'h0, q}, {24'h0, exp});
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        // reset values, data register excluded as it has none
        for (int i = 7; i <= 15; i++) begin
            if (i != 10) begin
                apb(1'b0, 16'hFEC0 + i[15:0], 8'h00);
                chk({24'h0, q}, 32'h0);
            end
        end
        foreach (rows[i]) begin
            apb(1'b1, rows[i][32:17], rows[i][16:9]);
            apb(1'b0, rows[i][32:17], 8'h00);
            chk({24'h0, q}, {24'h0, rows[i][8:1]});
            chk({31'h0, e}, {31'h0, rows[i][0]});
        end
        apb(1'b1, `IDX_CTPR, 8'h00);
        apb(1'b1, `IDX_DT0W, 8'h02);
        apb(1'b1, `IDX_DT1W, 8'h06);
        apb(1'b1, `IDX_XHW, 8'h00);
        apb(1'b1, `IDX_IRQ, 8'h55);
        apb(1'b1, `IDX_CTRL, 8'hA7);
        src.glitch();
        src.send(16'h01B4, 10, 16'h0);
        wait_end(8'h0A);
        apb(1'b0, `IDX_IRQ, 8'h00);
        chk({24'h0, q}, 32'h5F);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, `IDX_DATA, 8'h00);
        chk({24'h0, q}, 32'hB4);
        apb(1'b0, `IDX_SHIFT, 8'h00);
        chk({24'h0, q}, 32'h40);
        apb(1'b0, `IDX_CTPR, 8'h00);
        chk({24'h0, q}, 32'h02);
        // stop, then a negative phase frame with one bad bit
        apb(1'b1, `IDX_CTRL, 8'h00);
        apb(1'b0, `IDX_CTPR, 8'h00);
        chk({24'h0, q}, 32'h00);
        apb(1'b1, `IDX_IRQ, 8'h10);
        src.inv <= 1'b1;
        apb(1'b1, `IDX_CTRL, 8'hAF);
        src.send(16'h0001, 3, 16'h0002);
        wait_end(8'h0A);
        apb(1'b0, `IDX_IRQ, 8'h00);
        chk({24'h0, q}, 32'h32);
        chk({31'h0, hold_release}, 32'h1);
        apb(1'b1, `IDX_CTRL, 8'h00);
        // writing zero clears flags and enables, so the request drops
        apb(1'b1, `IDX_IRQ, 8'h00);
        apb(1'b0, `IDX_IRQ, 8'h00);
        chk({24'h0, q}, 32'h00);
        chk({31'h0, irq}, 32'h0);
        // start on an active line: no base clock in crystal hold, then
        // the level counts as a start edge once the hold ends
        xhold <= 1'b1;
        apb(1'b1, `IDX_CTRL, 8'hA7);
        repeat (300) @(posedge mclk);
        apb(1'b0, `IDX_CTPR, 8'h00);
        chk({24'h0, q}, 32'h00);
        xhold <= 1'b0;
        wait_end(8'h08);
        apb(1'b1, `IDX_CTRL, 8'h00);
        summarize;
    end
endmodule // tb
